// ===== logic/lutx_top.v
// transmit digital path of one line interface channel with apb registers
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
`include "lutx_regs.vh"

module lutx_top #(
   parameter MISS_CYC_E1 = (`LUTX_MISS_MCLK * `LUTX_PCLK_MHZ * 1000 +
                            `LUTX_MCLK_E1_KHZ - 1) / `LUTX_MCLK_E1_KHZ,
   parameter MISS_CYC_T1 = (`LUTX_MISS_MCLK * `LUTX_PCLK_MHZ * 1000 +
                            `LUTX_MCLK_T1_KHZ - 1) / `LUTX_MCLK_T1_KHZ,
   parameter [6:0] T1_EDGE = `LUTX_E1_120_EDGE,
   parameter [6:0] T1_FLAT = `LUTX_E1_120_FLAT
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        tx_line_clock,
   input  wire        tx_data_positive,
   input  wire        tx_data_negative,
   output reg         tx_line_tip,
   output reg         tx_line_ring,
   output reg  [6:0]  wave_dac_value,
   output reg         irq
);

   ////////////////////////////////////////////////////////////////////////
   // registers
   reg  [7:0]  tx_path_config;
   reg  [3:0]  pulse_template_select;
   reg  [5:0]  amplitude_scale_value;
   reg  [3:0]  wave_sample_index;
   reg  [1:0]  wave_interval_index;
   reg         wave_rw;
   reg         wave_done;
   reg  [6:0]  wave_sample_value;
   reg  [1:0]  irq_mask_group1;
   reg  [1:0]  irq_status_group1;
   reg         line_standard_select;
   reg  [6:0]  wave_ram [0:63];

   wire [7:0]  reg_idx = paddr[9:2];
   wire        wr_en   = psel & penable & pready & pwrite;
   wire        rd_en   = psel & penable & pready & ~pwrite;
   wire        status_rd = rd_en & (reg_idx == `LUTX_IDX_IRQ_STATUS);
   reg  [7:0]  next_rdata;
   reg         next_err;
   wire        ovf_event;
   wire        miss_event;

   always @* begin
      next_rdata = 8'h00;
      next_err   = 1'b0;
      case (reg_idx)
         `LUTX_IDX_PATH_CFG:    next_rdata = tx_path_config;
         `LUTX_IDX_PULSE_SEL:   next_rdata = {4'h0, pulse_template_select};
         `LUTX_IDX_AMP_SCALE:   next_rdata = {2'h0, amplitude_scale_value};
         `LUTX_IDX_RAM_ACCESS:  next_rdata = {wave_done, wave_rw,
                                   wave_interval_index, wave_sample_index};
         `LUTX_IDX_RAM_DATA:    next_rdata = {1'b0, wave_sample_value};
         `LUTX_IDX_IRQ_MASK:    next_rdata = {6'h00, irq_mask_group1};
         `LUTX_IDX_IRQ_STATUS:  next_rdata = {6'h00, irq_status_group1};
         `LUTX_IDX_GLOBAL_MODE: next_rdata = {7'h00, line_standard_select};
         default:               next_err   = 1'b1;
      endcase
      if (paddr[1:0] != 2'h0 || paddr[31:10] != 22'h000000) begin
         next_err = 1'b1;
      end
   end

   // zero wait state: answer in the first access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & next_err;
         if (psel & ~penable & ~pwrite & ~next_err) begin
            prdata <= {24'h000000, next_rdata};
         end else if (psel & ~penable) begin
            prdata <= 32'h00000000;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_path_config        <= 8'h00;
         pulse_template_select <= 4'h0;
         amplitude_scale_value <= `LUTX_SCALE_RESET;
         wave_sample_index     <= 4'h0;
         wave_interval_index   <= 2'h0;
         wave_rw               <= 1'b0;
         wave_done             <= 1'b0;
         wave_sample_value     <= 7'h00;
         irq_mask_group1       <= 2'h0;
         line_standard_select  <= 1'b0;
      end else begin
         if (wave_done) begin
            wave_done <= 1'b0;
            if (wave_rw) begin
               wave_sample_value <= wave_ram[{wave_interval_index,
                                              wave_sample_index}];
            end
         end
         if (wr_en && !pslverr) begin
            case (reg_idx)
               `LUTX_IDX_PATH_CFG:    tx_path_config <= pwdata[7:0];
               `LUTX_IDX_PULSE_SEL:   pulse_template_select <= pwdata[3:0];
               `LUTX_IDX_AMP_SCALE:   amplitude_scale_value <= pwdata[5:0];
               `LUTX_IDX_RAM_ACCESS: begin
                  wave_sample_index   <= pwdata[3:0];
                  wave_interval_index <= pwdata[5:4];
                  wave_rw             <= pwdata[`LUTX_F_RW];
                  wave_done           <= pwdata[`LUTX_F_DONE];
               end
               `LUTX_IDX_RAM_DATA:    wave_sample_value <= pwdata[6:0];
               `LUTX_IDX_IRQ_MASK:    irq_mask_group1 <= pwdata[1:0];
               `LUTX_IDX_GLOBAL_MODE: line_standard_select <= pwdata[0];
               default: ;
            endcase
         end
      end
   end

   // waveform ram write port, one ram per channel instance
   always @(posedge pclk) begin
      if (wave_done && !wave_rw) begin
         wave_ram[{wave_interval_index, wave_sample_index}]
            <= wave_sample_value;
      end
   end

   // status is clear on read; a new event in the same cycle wins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_group1 <= 2'h0;
         irq               <= 1'b0;
      end else begin
         irq_status_group1[`LUTX_F_OVERFLOW] <= ovf_event |
            (irq_status_group1[`LUTX_F_OVERFLOW] & ~status_rd);
         irq_status_group1[`LUTX_F_CLK_MISS] <= miss_event |
            (irq_status_group1[`LUTX_F_CLK_MISS] & ~status_rd);
         irq <= |(irq_status_group1 & irq_mask_group1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // link input synchronisers and edge detection
   reg  [2:0]  clk_sync;
   reg  [1:0]  dp_sync;
   reg  [1:0]  dn_sync;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_sync <= 3'h0;
         dp_sync  <= 2'h0;
         dn_sync  <= 2'h0;
      end else begin
         clk_sync <= {clk_sync[1:0], tx_line_clock};
         dp_sync  <= {dp_sync[0], tx_data_positive};
         dn_sync  <= {dn_sync[0], tx_data_negative};
      end
   end

   wire rise_edge = clk_sync[1] & ~clk_sync[2];
   wire fall_edge = ~clk_sync[1] & clk_sync[2];
   wire any_edge  = rise_edge | fall_edge;
   wire ui_tick   = tx_path_config[`LUTX_F_EDGE] ?
                    fall_edge : rise_edge;
   wire data_p    = dp_sync[1] ^ tx_path_config[`LUTX_F_INVERT];
   wire data_n    = dn_sync[1] ^ tx_path_config[`LUTX_F_INVERT];
   wire dual_rail = tx_path_config[`LUTX_F_RAIL];
   wire enc_sel   = tx_path_config[`LUTX_F_ENC_SEL];

   // missing clock watchdog
   reg  [15:0] miss_cnt;
   reg         miss_seen;
   wire [15:0] miss_limit = line_standard_select ?
                            MISS_CYC_T1[15:0] : MISS_CYC_E1[15:0];
   assign miss_event = (miss_cnt == miss_limit) & ~miss_seen;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         miss_cnt  <= 16'h0000;
         miss_seen <= 1'b0;
      end else if (any_edge) begin
         miss_cnt  <= 16'h0000;
         miss_seen <= 1'b0;
      end else if (miss_event) begin
         miss_seen <= 1'b1;
      end else if (!miss_seen) begin
         miss_cnt  <= miss_cnt + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // line encoder: symbol window, substitution on zero runs
   reg  [15:0] win;
   reg         last_neg;
   reg         b_odd;
   wire        hdb3 = ~line_standard_select;
   wire        zs   = enc_sel & ~dual_rail;
   wire [15:0] shifted = {win[13:0], data_p ? `LUTX_SYM_B : `LUTX_SYM_ZERO};
   wire [1:0]  out_sym = hdb3 ? win[7:6] : win[15:14];
   wire        out_b   = (out_sym == `LUTX_SYM_B);
   wire        out_v   = (out_sym == `LUTX_SYM_V);
   wire        par_now = b_odd ^ out_b;
   reg  [15:0] next_win;
   reg  [1:0]  enc_pol;

   always @* begin
      next_win = shifted;
      if (zs && !hdb3 && shifted == 16'h0000) begin
         next_win = {6'h00, `LUTX_SYM_V, `LUTX_SYM_B, 2'h0,
                     `LUTX_SYM_V, `LUTX_SYM_B};
      end else if (zs && hdb3 && shifted[7:0] == 8'h00) begin
         if (par_now) begin
            next_win = {shifted[15:8], 6'h00, `LUTX_SYM_V};
         end else begin
            next_win = {shifted[15:8], `LUTX_SYM_B, 4'h0,
                        `LUTX_SYM_V};
         end
      end
      if (out_v) begin
         enc_pol = last_neg ? `LUTX_POL_NEG : `LUTX_POL_POS;
      end else if (out_b) begin
         enc_pol = last_neg ? `LUTX_POL_POS : `LUTX_POL_NEG;
      end else begin
         enc_pol = `LUTX_POL_NONE;
      end
   end

   reg  [1:0]  line_pol;
   always @* begin
      if (!dual_rail) begin
         line_pol = enc_pol;
      end else if (data_p & ~data_n) begin
         line_pol = `LUTX_POL_NEG;
      end else if (~data_p & data_n) begin
         line_pol = `LUTX_POL_POS;
      end else begin
         line_pol = `LUTX_POL_NONE;
      end
   end

   // pulse history of the last four intervals
   reg  [7:0]  hist;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win      <= 16'h0000;
         last_neg <= 1'b1;
         b_odd    <= 1'b0;
         hist     <= 8'h00;
      end else if (ui_tick) begin
         win  <= dual_rail ? 16'h0000 : next_win;
         hist <= {hist[5:0], line_pol};
         if (!dual_rail && (out_b || out_v)) begin
            last_neg <= (enc_pol == `LUTX_POL_NEG);
            b_odd    <= out_v ? 1'b0 : par_now;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sub-phase timing: 16 samples per measured interval
   reg  [9:0]  period;
   reg  [9:0]  since_tick;
   reg  [5:0]  phase_cnt;
   reg  [3:0]  samp;
   wire [5:0]  step = (period[9:4] == 6'h00) ? 6'h01 : period[9:4];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period     <= 10'h000;
         since_tick <= 10'h000;
         phase_cnt  <= 6'h00;
         samp       <= 4'h0;
      end else if (ui_tick) begin
         period     <= since_tick;
         since_tick <= 10'h001;
         phase_cnt  <= 6'h00;
         samp       <= 4'h0;
      end else begin
         if (since_tick != 10'h3FF) begin
            since_tick <= since_tick + 10'h001;
         end
         if (phase_cnt >= step - 6'h01) begin
            phase_cnt <= 6'h00;
            if (samp != 4'hF) begin
               samp <= samp + 4'h1;
            end
         end else begin
            phase_cnt <= phase_cnt + 6'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pulse shaper: template lookup, scaling and overlap sum
   wire        prog_mode = (pulse_template_select[3:2] == 2'h3);
   reg  [6:0]  tpl_edge;
   reg  [6:0]  tpl_flat;
   always @* begin
      case (pulse_template_select)
         4'h0:    begin
            tpl_edge = `LUTX_E1_75_EDGE;
            tpl_flat = `LUTX_E1_75_FLAT;
         end
         4'h1:    begin
            tpl_edge = `LUTX_E1_120_EDGE;
            tpl_flat = `LUTX_E1_120_FLAT;
         end
         default: begin
            tpl_edge = T1_EDGE;
            tpl_flat = T1_FLAT;
         end
      endcase
   end

   wire [5:0]  scale = prog_mode ? amplitude_scale_value :
                       `LUTX_PRESET_SCL;
   wire [39:0] terms;
   genvar k;
   generate
      for (k = 0; k < 4; k = k + 1) begin : g_term
         localparam integer KI = k;
         wire [1:0]  kk   = KI[1:0];
         wire [6:0]  ram_s = wave_ram[{kk, samp}];
         wire [6:0]  rom_s = (kk != 2'h0) ? 7'h00 :
                       (samp == `LUTX_TPL_EDGE) ? tpl_edge :
                       (samp >= `LUTX_TPL_FLAT_LO &&
                        samp <= `LUTX_TPL_FLAT_HI) ? tpl_flat : 7'h00;
         wire [6:0]  smp  = prog_mode ? ram_s : rom_s;
         wire [17:0] prod = smp[5:0] * scale * 6'h1F;
         wire [7:0]  mag  = prog_mode ? prod[17:10] : {2'h0, smp[5:0]};
         wire [1:0]  pol  = hist[2*k+1:2*k];
         wire        neg  = smp[6] ^ (pol == `LUTX_POL_NEG);
         wire [9:0]  sv   = {2'h0, mag};
         assign terms[10*k+9:10*k] = (pol == `LUTX_POL_NONE) ? 10'h000 :
                                     neg ? (10'h000 - sv) : sv;
      end
   endgenerate

   wire [9:0]  sum = terms[9:0] + terms[19:10] + terms[29:20] +
                     terms[39:30];
   wire [9:0]  abs_sum = sum[9] ? (10'h000 - sum) : sum;
   wire        over = abs_sum > `LUTX_MAX_AMP;
   assign ovf_event = over;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wave_dac_value <= 7'h00;
         tx_line_tip    <= 1'b0;
         tx_line_ring   <= 1'b0;
      end else begin
         wave_dac_value <= {sum[9], over ? 6'h3F : abs_sum[5:0]};
         tx_line_tip    <= ~sum[9] & (sum != 10'h000);
         tx_line_ring   <= sum[9];
      end
   end

endmodule

// ===== inc/lutx_regs.vh
// register map, field positions, reset values and timing for the tx path
//
// Operation
// - global line-standard bit 0 selects E1, 1 selects T1/J1.
// - clock absent over 70 master clock cycles raises a maskable event.
// - data sampled on rising or falling clock edge per edge-select bit.
// - data-inversion bit sets the active level of the data inputs.
// - rail-mode 0 uses single data input, 1 uses positive and negative rails.
// - T1/J1 single rail encodes B8ZS or AMI per encoding-select bit.
// - E1 single rail encodes HDB3 or AMI per encoding-select bit.
// - dual rail bypasses the line encoder in either line mode.
// - dual rail: P1N0 negative, P0N1 positive, equal rails give space.
// - E1 code 0000 is 75 ohm pulse, 0001 the 120 ohm pulse.
// - T1 offers five preset templates, one per cable-length grade; the code gives every code 0010 to 1011 the one T1_EDGE/T1_FLAT template.
// - J1 uses preset template code 0111.
// - template code 11xx drives the pulse from the waveform RAM.
// - programmable pulse spans 4 intervals of 16 samples each.
// - samples are 7-bit signed magnitude, -63 to +63.
// - each channel has its own 64-byte waveform RAM.
// - eight standard templates sit in local ROM; the code holds three: 75 ohm, 120 ohm and T1_EDGE/T1_FLAT.
// - each scaling step moves the programmable pulse by a fixed percentage.
// - overlapping pulses beyond maximum set overflow flag, maskable event.
// - preset templates ignore amplitude scaling.
// - scaling resets to 100001, each step about 3 percent.
`ifndef LUTX_REGS_VH
`define LUTX_REGS_VH

// register indices, byte address is four times the index
`define LUTX_IDX_PATH_CFG    8'h02
`define LUTX_IDX_PULSE_SEL   8'h03
`define LUTX_IDX_AMP_SCALE   8'h04
`define LUTX_IDX_RAM_ACCESS  8'h05
`define LUTX_IDX_RAM_DATA    8'h06
`define LUTX_IDX_IRQ_MASK    8'h12
`define LUTX_IDX_IRQ_STATUS  8'h17
`define LUTX_IDX_GLOBAL_MODE 8'h40

// tx_path_config fields
`define LUTX_F_ENC_SEL   0
`define LUTX_F_RAIL      1
`define LUTX_F_INVERT    2
`define LUTX_F_EDGE      3
// irq mask / status fields
`define LUTX_F_OVERFLOW  0
`define LUTX_F_CLK_MISS  1
// tx_wave_ram_access fields
`define LUTX_F_RW        6
`define LUTX_F_DONE      7

`define LUTX_SCALE_RESET 6'h21
`define LUTX_SCALE_UNITY 6'h21
`define LUTX_PRESET_SCL  6'h21
`define LUTX_MAX_AMP     10'h03F

// symbols in the encoder window
`define LUTX_SYM_ZERO    2'h0
`define LUTX_SYM_B       2'h1
`define LUTX_SYM_V       2'h2

// line polarity codes
`define LUTX_POL_NONE    2'h0
`define LUTX_POL_POS     2'h1
`define LUTX_POL_NEG     2'h2

// preset template samples: edge sample, flat samples, then zero
`define LUTX_TPL_EDGE    4'h3
`define LUTX_TPL_FLAT_LO 4'h4
`define LUTX_TPL_FLAT_HI 4'hB
`define LUTX_E1_75_EDGE  7'h0C
`define LUTX_E1_75_FLAT  7'h30
`define LUTX_E1_120_EDGE 7'h0F
`define LUTX_E1_120_FLAT 7'h3C

// timing
`define LUTX_PCLK_MHZ    250
`define LUTX_MISS_MCLK   70
`define LUTX_MCLK_E1_KHZ 2048
`define LUTX_MCLK_T1_KHZ 1544

`endif

// ===== dv/lutx_props.sv
// port-level checks of the tx path apb slave and line outputs
`timescale 1ns/10ps
module lutx_props (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        tx_line_clock,
   input wire        tx_data_positive,
   input wire        tx_data_negative,
   input wire        tx_line_tip,
   input wire        tx_line_ring,
   input wire [6:0]  wave_dac_value,
   input wire        irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s; psel && !penable; endsequence
   sequence rd_end_s; psel && penable && pready && !pwrite; endsequence
   setup_ready_a: assert property (setup_s |=> pready)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   ready_cause_a: assert property (pready |-> $past(psel && !penable))
      else $error("ready without setup");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   upper_zero_a: assert property (prdata[31:8] == 24'h000000)
      else $error("read data upper bits set");
   err_data_a: assert property (psel && penable && pready && !pwrite &&
      pslverr |-> prdata == 32'h00000000)
      else $error("refused read returns data");
   misalign_a: assert property (setup_s ##0 (paddr[1:0] != 2'h0) |=> pslverr)
      else $error("misaligned access accepted");
   unmapped_a: assert property (setup_s ##0 (paddr[9:2] == 8'h07) |=> pslverr)
      else $error("unmapped access accepted");
   rdata_hold_a: assert property (rd_end_s ##1 !psel |-> $stable(prdata))
      else $error("read data moved before next setup");
   rails_excl_a: assert property (!(tx_line_tip && tx_line_ring))
      else $error("tip and ring both driven");
endmodule
////////////////////////////////////////////////////////////
bind lutx_top lutx_props i_lutx_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .tx_line_clock(tx_line_clock), .tx_data_positive(tx_data_positive),
   .tx_data_negative(tx_data_negative), .tx_line_tip(tx_line_tip),
   .tx_line_ring(tx_line_ring), .wave_dac_value(wave_dac_value), .irq(irq));

// ===== dv/lutx_line_src.sv
// system-side source of transmit clock and rail data
`timescale 1ns/10ps
module lutx_line_src (
   input  wire run,
   input  wire fall,
   input  wire pin,
   input  wire nin,
   output reg  tx_line_clock,
   output reg  tx_data_positive,
   output reg  tx_data_negative
);
   initial begin
      tx_line_clock = 1'b0;
      tx_data_positive = 1'b0;
      tx_data_negative = 1'b0;
   end
   // data moves on the inactive edge, 32 ns period
   always begin
      if (run) begin
         tx_line_clock = fall;
         tx_data_positive = pin;
         tx_data_negative = nin;
         #16;
         tx_line_clock = !fall;
         #16;
      end else begin
         // clock stands still, data lines carry no meaning
         tx_data_positive = !tx_data_positive;
         tx_data_negative = !tx_data_negative;
         #16;
      end
   end
endmodule

// ===== dv/lutx_top_test.sv
// self-checking bench of the tx path
`timescale 1ns/10ps
`include "lutx_regs.vh"
module lutx_top_test;
   reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   reg  [31:0] paddr = 0, pwdata = 0, rv;
   reg         re, lc = 0, run = 1, fall = 0, pin = 0, nin = 0, mon = 0;
   wire [31:0] prdata;
   wire        pready, pslverr, tclk, tdp, tdn, tip, ring, irq;
   wire [6:0]  dac;
   integer     mismatches = 0, check_count = 0, tipc, ringc, dmax, idle = 0;
   integer     negc;
   integer     i, k;
   always #2 pclk = ~pclk;
   lutx_top #(.MISS_CYC_E1(40), .MISS_CYC_T1(50)) i_lutx_top (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_line_clock(tclk), .tx_data_positive(tdp),
      .tx_data_negative(tdn), .tx_line_tip(tip), .tx_line_ring(ring),
      .wave_dac_value(dac), .irq(irq));
   lutx_line_src i_lutx_line_src (.run(run), .fall(fall), .pin(pin),
      .nin(nin), .tx_line_clock(tclk), .tx_data_positive(tdp),
      .tx_data_negative(tdn));
   always @(posedge pclk) begin
      idle <= (tclk !== lc) ? 0 : idle + 1;
      lc <= tclk;
      if (mon) begin
         tipc <= tipc + tip;
         ringc <= ringc + ring;
         negc <= negc + dac[6];
         if (dac[5:0] > dmax) dmax <= dac[5:0];
      end
   end
   ////////////////////////////////////////////////////////////
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", check_count, mismatches);
         if (mismatches == 0 && check_count > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] s, input [31:0] e);
      begin
         check_count = check_count + 1;
         if (s !== e) begin
            mismatches = mismatches + 1;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
         end
      end
   endtask
   task xfer(input w, input [31:0] a, input [31:0] d);
      integer n;
      begin
         psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
         @(posedge pclk);
         penable <= 1;
         n = 0;
         do begin
            @(posedge pclk);
            n = n + 1;
         end while (pready !== 1'b1 && n < 50);
         if (n >= 50) begin
            mismatches = mismatches + 1;
            give_verdict;
         end
         rv = prdata; re = pslverr; psel <= 0; penable <= 0;
         @(posedge pclk);
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      xfer(1, {22'h0, a, 2'h0}, {24'h0, d});
   endtask
   task rd(input [7:0] a);
      xfer(0, {22'h0, a, 2'h0}, 32'h0);
   endtask
   task ramw(input [1:0] u, input [3:0] s, input [6:0] v);
      begin
         wr(`LUTX_IDX_RAM_DATA, {1'b0, v});
         wr(`LUTX_IDX_RAM_ACCESS, {2'b10, u, s});
      end
   endtask
   task watch(input integer n);
      begin
         tipc = 0; ringc = 0; dmax = 0; negc = 0; mon = 1;
         repeat (n) @(posedge pclk);
         mon = 0;
      end
   endtask
   ////////////////////////////////////////////////////////////
   localparam logic [15:0] RT [8] = '{16'h1700, 16'h0200, 16'h0300,
      16'h0421, 16'h0500, 16'h0600, 16'h1200, 16'h4000};
   task t_regs;
      begin
         for (i = 0; i < 8; i++) begin
            rd(RT[i][15:8]);
            chk(rv, RT[i][7:0]);
         end
         rd(8'h07);
         chk(re, 1);
         chk(rv, 0);
         xfer(0, 32'h9, 32'h0);
         chk(re, 1);
         $display("t_regs done");
      end
   endtask
   task t_ram;
      begin
         ramw(2, 5, 7'h45);
         ramw(1, 10, 7'h2A);
         wr(`LUTX_IDX_RAM_DATA, 0);
         wr(`LUTX_IDX_RAM_ACCESS, 8'hE5);
         rd(`LUTX_IDX_RAM_DATA);
         chk(rv, 32'h45);
         wr(`LUTX_IDX_RAM_ACCESS, 8'hDA);
         rd(`LUTX_IDX_RAM_DATA);
         chk(rv, 32'h2A);
         rd(`LUTX_IDX_RAM_ACCESS);
         chk(rv[7], 0);
         $display("t_ram done");
      end
   endtask
   // global, config, falling, p, n, tip seen, ring seen
   localparam logic [9:0] CT [11] = '{10'b0_0000_0_10_11,
      10'b0_0000_0_00_00, 10'b0_0001_0_00_11, 10'b1_0001_0_00_11,
      10'b1_0000_0_00_00, 10'b0_0011_0_10_01, 10'b0_0010_0_01_10,
      10'b1_0011_0_11_00, 10'b0_0110_0_10_10, 10'b0_1010_1_01_10,
      10'b0_0100_0_11_00};
   task t_codes;
      begin
         wr(`LUTX_IDX_PULSE_SEL, 0);
         for (i = 0; i < 11; i++) begin
            wr(`LUTX_IDX_GLOBAL_MODE, CT[i][9]);
            wr(`LUTX_IDX_PATH_CFG, CT[i][8:5]);
            fall <= CT[i][4]; pin <= CT[i][3]; nin <= CT[i][2];
            repeat (120) @(posedge pclk);
            watch(200);
            chk(tipc > 0, CT[i][1]);
            chk(ringc > 0, CT[i][0]);
            chk(negc > 0, CT[i][0]);
         end
         $display("t_codes done");
      end
   endtask
   // template, scale, peak magnitude
   localparam logic [15:0] ST [6] = '{{4'h0, 6'h21, 6'h30},
      {4'h1, 6'h21, 6'h3C}, {4'h0, 6'h3F, 6'h30}, {4'h7, 6'h21, 6'h3C},
      {4'hC, 6'h22, 6'd32}, {4'hE, 6'h20, 6'd31}};
   task t_shape;
      begin
         for (i = 0; i < 64; i++) ramw(i / 16, i % 16, i < 16 ? 7'h20 : 7'h0);
         wr(`LUTX_IDX_GLOBAL_MODE, 0);
         wr(`LUTX_IDX_PATH_CFG, 8'h02);
         fall <= 0; pin <= 0; nin <= 1;
         for (i = 0; i < 6; i++) begin
            wr(`LUTX_IDX_PULSE_SEL, ST[i][15:12]);
            wr(`LUTX_IDX_AMP_SCALE, ST[i][11:6]);
            repeat (100) @(posedge pclk);
            watch(160);
            chk(dmax, ST[i][5:0]);
            chk(tipc > 0, 1);
         end
         for (i = 0; i < 16; i++) ramw(0, i, 7'h3F);
         wr(`LUTX_IDX_AMP_SCALE, 8'h3F);
         wr(`LUTX_IDX_IRQ_MASK, 8'h01);
         repeat (100) @(posedge pclk);
         watch(100);
         chk(dmax, 63);
         chk(irq, 1);
         rd(`LUTX_IDX_IRQ_STATUS);
         chk(rv[0], 1);
         wr(`LUTX_IDX_IRQ_MASK, 8'h00);
         repeat (3) @(posedge pclk);
         chk(irq, 0);
         wr(`LUTX_IDX_PULSE_SEL, 0);
         $display("t_shape done");
      end
   endtask
   task t_miss;
      begin
         rd(`LUTX_IDX_IRQ_STATUS);
         run <= 0;
         repeat (100) @(posedge pclk);
         chk(irq, 0);
         rd(`LUTX_IDX_IRQ_STATUS);
         chk(rv[1], 1);
         for (i = 0; i < 2; i++) begin
            wr(`LUTX_IDX_GLOBAL_MODE, i);
            run <= 1;
            repeat (60) @(posedge pclk);
            rd(`LUTX_IDX_IRQ_STATUS);
            wr(`LUTX_IDX_IRQ_MASK, 8'h02);
            run <= 0;
            k = 0;
            while (irq !== 1'b1 && k < 300) begin
               @(posedge pclk);
               k = k + 1;
            end
            if (k >= 300) begin
               mismatches = mismatches + 1;
               give_verdict;
            end
            chk(idle >= 40 + 10 * i && idle <= 48 + 10 * i, 1);
            rd(`LUTX_IDX_IRQ_STATUS);
            repeat (3) @(posedge pclk);
            chk(irq, 0);
         end
         $display("t_miss done");
      end
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      t_regs;
      t_ram;
      t_codes;
      t_shape;
      t_miss;
      give_verdict;
   end
   initial begin
      #390000;
      mismatches = mismatches + 1;
      give_verdict;
   end
endmodule
